// ===== core/rwd_pkg.sv
// Shared constants for the runaway watchdog timer
package rwd_pkg;
    // Register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [ADDR_W-1:0] MODE_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] CMD_OFS = 4'h4;
    localparam logic [ADDR_W-1:0] STAT_OFS = 4'h8;
    // Mode register fields
    localparam int EN_BIT = 7;
    localparam int PSEL_HI = 6;
    localparam int PSEL_LO = 5;
    localparam int RESET_ON_RUNAWAY_BIT = 1;
    localparam logic [7:0] MODE_RST = 8'h80;
    // Status register fields
    localparam int ST_DETECT_BIT = 0;
    localparam int ST_ACTIVE_BIT = 1;
    localparam int ST_HELD_BIT = 2;
    // Command codes
    localparam logic [7:0] CMD_CLEAR = 8'h4E;
    localparam logic [7:0] CMD_DISABLE = 8'hB1;
    // Counter shape: stages at half rate, bit hit for shortest period
    localparam int CNT_STAGES = 22;
    localparam int PERIOD_BASE = 15;
    // Watchdog enable state
    typedef enum logic [0:0] {RWD_ACTIVE, RWD_OFF} rwd_state_t;
endpackage : rwd_pkg

// ===== core/rwd_counter.sv
// Half-rate binary counter with detection period decode
`timescale 1ns/1ps
`default_nettype none
module rwd_counter import rwd_pkg::*; #(
    parameter int STAGES = CNT_STAGES
) (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset
    input wire logic run_i, // Count enable
    input wire logic clr_i, // Clear to zero
    input wire logic [1:0] sel_i, // Detection period select
    output logic [STAGES-1:0] cnt_o, // Counter value
    output logic ovf_o // One-cycle overflow event
);
    logic tick_q, tick_d;
    logic [STAGES-1:0] cnt_q, cnt_d;
    logic ovf_q, ovf_d;

    // Period boundary: low bits zero, select bit set
    function automatic logic hit(input logic [STAGES-1:0] c,
                                 input logic [1:0] s);
        int idx;
        logic [STAGES-1:0] m;
        idx = PERIOD_BASE + 2 * int'(s);
        m = STAGES'((64'h1 << idx) - 64'h1);
        hit = ((c & m) == '0) && c[idx];
    endfunction : hit

    // Next counter state
    always_comb begin
        tick_d = tick_q;
        cnt_d = cnt_q;
        ovf_d = 1'b0;
        if (clr_i) begin
            tick_d = 1'b0;
            cnt_d = '0;
        end else if (run_i) begin
            tick_d = ~tick_q; // Half system rate
            if (tick_q) begin
                cnt_d = cnt_q + STAGES'(1);
                ovf_d = hit(cnt_d, sel_i);
            end
        end
    end

    // Counter registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_q <= 1'b0;
            cnt_q <= '0;
            ovf_q <= 1'b0;
        end else begin
            tick_q <= tick_d;
            cnt_q <= cnt_d;
            ovf_q <= ovf_d;
        end
    end

    assign cnt_o = cnt_q;
    assign ovf_o = ovf_q;

    // Checks
    property p_half_rate;
        @(posedge clk_i) disable iff (rst_i)
        run_i && !clr_i && tick_q |=> cnt_q == $past(cnt_q) + STAGES'(1);
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("counter did not step on half-rate tick");
    property p_ovf_point;
        @(posedge clk_i) disable iff (rst_i)
        ovf_q |-> hit(cnt_q, $past(sel_i));
    endproperty
    a_ovf_point: assert property (p_ovf_point)
        else $error("overflow away from selected period");
endmodule : rwd_counter
`default_nettype wire

// ===== core/rwd_wb_slave.sv
// Classic Wishbone slave for the watchdog registers
`timescale 1ns/1ps
`default_nettype none
module rwd_wb_slave import rwd_pkg::*; (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset
    input wire logic wb_cyc_i, // Cycle
    input wire logic wb_stb_i, // Strobe
    input wire logic wb_we_i, // Write enable
    input wire logic [ADDR_W-1:0] wb_adr_i, // Byte address
    input wire logic [3:0] wb_sel_i, // Byte selects
    input wire logic [DATA_W-1:0] wb_dat_i, // Write data
    output logic [DATA_W-1:0] wb_dat_o, // Read data
    output logic wb_ack_o, // Acknowledge
    input wire logic block_i, // Register access blocked
    input wire logic [7:0] mode_i, // Mode register view
    input wire logic [7:0] stat_i, // Status register view
    output logic mode_we_o, // Mode write strobe
    output logic cmd_we_o, // Command write strobe
    output logic [7:0] wdata_o // Write byte
);
    logic ack_q, ack_d;
    logic [DATA_W-1:0] dat_q, dat_d;
    logic req;
    logic wr;

    // Decode of a fresh request
    assign req = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr = req && wb_we_i && wb_sel_i[0] && !block_i;
    assign mode_we_o = wr && (wb_adr_i == MODE_OFS);
    assign cmd_we_o = wr && (wb_adr_i == CMD_OFS);
    assign wdata_o = wb_dat_i[7:0];

    // Read mux; blocked and unmapped reads give zero
    always_comb begin
        ack_d = req;
        dat_d = '0;
        if (req && !wb_we_i && !block_i) begin
            case (wb_adr_i)
                MODE_OFS: dat_d = {24'h0, mode_i};
                STAT_OFS: dat_d = {24'h0, stat_i};
                default: dat_d = '0;
            endcase
        end
    end

    // Bus registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
endmodule : rwd_wb_slave
`default_nettype wire

// ===== core/rwd_top.sv
// Runaway watchdog timer top level
//
// Contract
// - Four detection periods of 2^16, 2^18, 2^20, 2^22 clocks.
// - Reaching the selected period uncleared raises the runaway interrupt.
// - Writing 4EH to the command register zeroes the counter.
// - Period select 01 with enable set gives 2^18 clocks.
// - Disable needs enable cleared first, then B1H written.
// - Reset mode turns a runaway into an internal reset.
// - Uncleared, the interrupt recurs every twice the detection time.
// - Counter runs in run and light idle, halts in deep idle, stop.
// - No interrupt delivered in light idle; disable before halting.
// - Counting continues while the external bus is released.
// - Runaway in bus release is held and raised right after it.
// - Register access is blocked during bus release.
// - Counting starts right after reset release.
// - Reset values: enable one, select 00, reset mode zero.
// - Without reset mode, detection is held until the clear code.
// - Non-maskable interrupt; 22-stage counter at half clock.
// - Setting the enable bit alone re-enables the watchdog.
//
// Our own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rwd_top import rwd_pkg::*; #(
    parameter int STAGES = CNT_STAGES
) (
    input wire logic clk_i, // System clock, 40 MHz
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic wb_cyc_i, // Wishbone cycle
    input wire logic wb_stb_i, // Wishbone strobe
    input wire logic wb_we_i, // Wishbone write enable
    input wire logic [ADDR_W-1:0] wb_adr_i, // Wishbone byte address
    input wire logic [3:0] wb_sel_i, // Wishbone byte selects
    input wire logic [DATA_W-1:0] wb_dat_i, // Wishbone write data
    output logic [DATA_W-1:0] wb_dat_o, // Wishbone read data
    output logic wb_ack_o, // Wishbone acknowledge
    input wire logic bus_grant_n_i, // Low while bus is released
    input wire logic light_idle_i, // Light idle mode
    input wire logic deep_idle_i, // Deep idle mode
    input wire logic stop_i, // Stop mode
    output logic runaway_interrupt_o, // Non-maskable interrupt pulse
    output logic internal_reset_o // Internal reset request pulse
);
    rwd_state_t state_q, state_d;
    logic en_q, en_d;
    logic [1:0] psel_q, psel_d;
    logic reset_on_runaway_q, reset_on_runaway_d;
    logic detect_q, detect_d;
    logic held_q, held_d;
    logic int_q, int_d;
    logic irst_q, irst_d;
    logic mode_we;
    logic cmd_we;
    logic [7:0] wdata;
    logic [7:0] mode_view;
    logic [7:0] stat_view;
    logic clr_cmd;
    logic dis_cmd;
    logic nmi_ev;
    logic fire;
    logic run;
    logic clr;
    logic ovf;
    logic [STAGES-1:0] cnt;

    // Register bus slave
    rwd_wb_slave u_bus (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .block_i(!bus_grant_n_i),
        .mode_i(mode_view),
        .stat_i(stat_view),
        .mode_we_o(mode_we),
        .cmd_we_o(cmd_we),
        .wdata_o(wdata)
    );

    // Register views
    always_comb begin
        mode_view = 8'h00;
        mode_view[EN_BIT] = en_q;
        mode_view[PSEL_HI:PSEL_LO] = psel_q;
        mode_view[RESET_ON_RUNAWAY_BIT] = reset_on_runaway_q;
        stat_view = 8'h00;
        stat_view[ST_DETECT_BIT] = detect_q;
        stat_view[ST_ACTIVE_BIT] = (state_q == RWD_ACTIVE);
        stat_view[ST_HELD_BIT] = held_q;
    end

    // Command decode; other codes fall through unused
    assign clr_cmd = cmd_we && (wdata == CMD_CLEAR);
    assign dis_cmd = cmd_we && (wdata == CMD_DISABLE);

    // Counter runs in run and light idle only, keeps going in release
    assign run = (state_q == RWD_ACTIVE) && !deep_idle_i
                 && !stop_i;
    assign clr = clr_cmd || (state_q == RWD_OFF);

    // Half-rate binary counter
    rwd_counter #(
        .STAGES(STAGES)
    ) u_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run),
        .clr_i(clr),
        .sel_i(psel_q),
        .cnt_o(cnt),
        .ovf_o(ovf)
    );

    // Interrupt gating: held through release, dropped in light idle
    assign nmi_ev = ovf && !reset_on_runaway_q && !light_idle_i;
    assign fire = held_q && bus_grant_n_i && !light_idle_i;

    // Next control state
    always_comb begin
        state_d = state_q;
        en_d = en_q;
        psel_d = psel_q;
        reset_on_runaway_d = reset_on_runaway_q;
        if (mode_we) begin
            en_d = wdata[EN_BIT];
            psel_d = wdata[PSEL_HI:PSEL_LO];
            reset_on_runaway_d = wdata[RESET_ON_RUNAWAY_BIT];
        end
        case (state_q)
            RWD_ACTIVE: begin
                if (dis_cmd && !en_q) begin
                    state_d = RWD_OFF;
                end
            end
            RWD_OFF: begin
                if (mode_we && wdata[EN_BIT]) begin
                    state_d = RWD_ACTIVE;
                end
            end
            default: state_d = RWD_ACTIVE;
        endcase
        // Set wins over clear
        detect_d = ovf || (detect_q && !clr_cmd);
        held_d = nmi_ev || (held_q && !fire);
        int_d = fire;
        irst_d = ovf && reset_on_runaway_q;
    end

    // Control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= RWD_ACTIVE;
            en_q <= MODE_RST[EN_BIT];
            psel_q <= MODE_RST[PSEL_HI:PSEL_LO];
            reset_on_runaway_q <= MODE_RST[RESET_ON_RUNAWAY_BIT];
            detect_q <= 1'b0;
            held_q <= 1'b0;
            int_q <= 1'b0;
            irst_q <= 1'b0;
        end else begin
            state_q <= state_d;
            en_q <= en_d;
            psel_q <= psel_d;
            reset_on_runaway_q <= reset_on_runaway_d;
            detect_q <= detect_d;
            held_q <= held_d;
            int_q <= int_d;
            irst_q <= irst_d;
        end
    end

    assign runaway_interrupt_o = int_q;
    assign internal_reset_o = irst_q;

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // Set wins: an overflow in the clear cycle keeps the flag
    property p_clear;
        clr_cmd |=> cnt == '0 && (!detect_q || $past(ovf));
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear code did not zero the counter");

    property p_disable;
        state_q == RWD_ACTIVE && dis_cmd && !en_q |=> state_q == RWD_OFF;
    endproperty
    a_disable: assert property (p_disable)
        else $error("two-step disable did not stop the watchdog");

    property p_dis_guard;
        state_q == RWD_ACTIVE && en_q |=> state_q == RWD_ACTIVE;
    endproperty
    a_dis_guard: assert property (p_dis_guard)
        else $error("watchdog stopped while enable bit set");

    property p_reenable;
        state_q == RWD_OFF && mode_we && wdata[EN_BIT]
            |=> state_q == RWD_ACTIVE ##1 cnt == '0;
    endproperty
    a_reenable: assert property (p_reenable)
        else $error("enable bit did not restart the watchdog");

    property p_reset_mode;
        ovf && reset_on_runaway_q |=> internal_reset_o && !runaway_interrupt_o;
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("reset mode runaway gave no internal reset");

    property p_idle_quiet;
        light_idle_i |=> !runaway_interrupt_o;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("interrupt delivered in light idle");

    property p_release_hold;
        !bus_grant_n_i && held_q |=> !runaway_interrupt_o && held_q;
    endproperty
    a_release_hold: assert property (p_release_hold)
        else $error("held runaway lost or raised during release");

    property p_release_fire;
        held_q && bus_grant_n_i && !light_idle_i
            |=> runaway_interrupt_o ##1 !runaway_interrupt_o;
    endproperty
    a_release_fire: assert property (p_release_fire)
        else $error("held runaway not raised after release");

    property p_halt;
        (deep_idle_i || stop_i) && !clr |=> $stable(cnt);
    endproperty
    a_halt: assert property (p_halt)
        else $error("counter moved in deep idle or stop");

    property p_block;
        !bus_grant_n_i |-> !mode_we && !cmd_we;
    endproperty
    a_block: assert property (p_block)
        else $error("register write during bus release");

    property p_detect_hold;
        detect_q && !clr_cmd |=> detect_q;
    endproperty
    a_detect_hold: assert property (p_detect_hold)
        else $error("detection state dropped without clear code");

    // Set wins: an overflow always raises the detection flag
    property p_detect_set;
        ovf |=> detect_q;
    endproperty
    a_detect_set: assert property (p_detect_set)
        else $error("overflow did not raise detection flag");

    // Plain mode never asks for an internal reset
    property p_plain_no_reset;
        !reset_on_runaway_q |=> !internal_reset_o;
    endproperty
    a_plain_no_reset: assert property (p_plain_no_reset)
        else $error("internal reset outside reset mode");

    // Disabled watchdog keeps the counter at zero
    property p_off_clear;
        state_q == RWD_OFF |=> cnt == '0;
    endproperty
    a_off_clear: assert property (p_off_clear)
        else $error("counter not held at zero while disabled");

    // Stray command codes leave state and enable alone
    property p_stray_cmd;
        cmd_we && wdata != CMD_CLEAR && wdata != CMD_DISABLE
            |=> $stable(state_q) && $stable(en_q);
    endproperty
    a_stray_cmd: assert property (p_stray_cmd)
        else $error("stray command code changed the watchdog");

    // Interrupt only ever comes from a held event outside release
    property p_nmi_source;
        runaway_interrupt_o |-> $past(held_q) && $past(bus_grant_n_i);
    endproperty
    a_nmi_source: assert property (p_nmi_source)
        else $error("interrupt without a held event");

    // Light idle overflow is dropped, never held
    property p_idle_drop;
        light_idle_i && !held_q |=> !held_q;
    endproperty
    a_idle_drop: assert property (p_idle_drop)
        else $error("overflow held during light idle");

    // Two running cycles in release give one counter step
    property p_release_count;
        (!bus_grant_n_i && run && !clr) ##1 (!bus_grant_n_i && run && !clr)
            |=> cnt != $past(cnt, 2);
    endproperty
    a_release_count: assert property (p_release_count)
        else $error("counter stalled during bus release");

    // Main scenarios
    c_nmi: cover property (held_q ##1 runaway_interrupt_o);
    c_reset: cover property (internal_reset_o);
    c_off: cover property (state_q == RWD_OFF ##1 state_q == RWD_ACTIVE);
    c_idle_run: cover property (light_idle_i && run);
    c_held_release: cover property (!bus_grant_n_i && held_q);
endmodule : rwd_top
`default_nettype wire

// ===== bench/rwd_cpu_model.sv
// Behavioural model of the core's interrupt, reset and bus logic
`timescale 1ns/1ps
`default_nettype none
module rwd_cpu_model (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset
    input wire logic bus_request_n_i, // Low asks for bus release
    input wire logic runaway_interrupt_i, // Watchdog interrupt
    input wire logic internal_reset_i, // Watchdog reset request
    output logic bus_grant_n_o, // Low while bus released
    output logic [7:0] nmi_cnt_o, // Interrupts taken
    output logic [7:0] rst_cnt_o // Reset requests seen
);
    logic [1:0] dly_q;
    // Grant after three cycles of request, hand back at once
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_q <= 2'h0;
            bus_grant_n_o <= 1'b1;
        end else if (bus_request_n_i) begin
            dly_q <= 2'h0;
            bus_grant_n_o <= 1'b1;
        end else if (dly_q != 2'h2) begin
            dly_q <= dly_q + 2'h1;
        end else begin
            bus_grant_n_o <= 1'b0;
        end
    end
    // Interrupt has no mask: every pulse is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_cnt_o <= 8'h00;
            rst_cnt_o <= 8'h00;
        end else begin
            nmi_cnt_o <= nmi_cnt_o + {7'h00, runaway_interrupt_i};
            rst_cnt_o <= rst_cnt_o + {7'h00, internal_reset_i};
        end
    end
endmodule : rwd_cpu_model
`default_nettype wire

// ===== bench/rwd_top_tb_top.sv
// Self-checking testbench for the runaway watchdog top level
`timescale 1ns/1ps
`default_nettype none
module rwd_top_tb_top;
    import rwd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [ADDR_W-1:0] wb_adr_i = 4'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [DATA_W-1:0] wb_dat_i = 32'h0;
    logic [DATA_W-1:0] wb_dat_o;
    logic wb_ack_o;
    logic bus_grant_n;
    logic bus_request_n = 1'b1;
    logic light_idle = 1'b0;
    logic deep_idle = 1'b0;
    logic stop = 1'b0;
    logic runaway_interrupt;
    logic internal_reset;
    logic [7:0] nmi_cnt;
    logic [7:0] rst_cnt;
    int n_mismatch = 0;
    int total_checks = 0;
    int cyc_n = 0;
    localparam logic [31:0] ACT = 32'h1 << ST_ACTIVE_BIT;
    localparam logic [31:0] DET = 32'h1 << ST_DETECT_BIT;

    // Clock and cycle count
    always #12.5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_n <= cyc_n + 1;

    rwd_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .bus_grant_n_i(bus_grant_n),
        .light_idle_i(light_idle), .deep_idle_i(deep_idle),
        .stop_i(stop), .runaway_interrupt_o(runaway_interrupt),
        .internal_reset_o(internal_reset));

    rwd_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i),
        .bus_request_n_i(bus_request_n),
        .runaway_interrupt_i(runaway_interrupt),
        .internal_reset_i(internal_reset), .bus_grant_n_o(bus_grant_n),
        .nmi_cnt_o(nmi_cnt), .rst_cnt_o(rst_cnt));

    // Verdict and end of run
    task automatic test_done();
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // Compare register data
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: reg %h want %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk_reg

    // Compare event counts
    task automatic chk_cnt(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: count %h want %h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk_cnt

    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        q = wb_dat_o;
        if (n >= 40) begin
            $display("unexpected at %0t: no acknowledge", $time);
            n_mismatch++;
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk_reg(q, exp);
    endtask : rd

    // Wait, bounded, for the grant line to reach a level
    task automatic wait_grant(input logic lvl);
        int n;
        n = 0;
        while (bus_grant_n !== lvl && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (bus_grant_n !== lvl) begin
            $display("unexpected at %0t: grant line stuck", $time);
            n_mismatch++;
        end
    endtask : wait_grant

    // Values after reset, unmapped and command reads
    task automatic t_reset();
        rd(MODE_OFS, {24'h0, MODE_RST});
        rd(STAT_OFS, ACT);
        rd(CMD_OFS, 32'h0);
        rd(4'hC, 32'h0);
    endtask : t_reset

    // Period select and reset mode fields hold what was written
    task automatic t_mode();
        wr(MODE_OFS, 8'hA2);
        rd(MODE_OFS, 32'hA2);
        wr(MODE_OFS, 8'h80);
        rd(MODE_OFS, 32'h80);
    endtask : t_mode

    // Two-step disable, stray codes, re-enable
    task automatic t_disable();
        wr(CMD_OFS, CMD_DISABLE);
        rd(STAT_OFS, ACT);
        wr(MODE_OFS, 8'h00);
        wr(CMD_OFS, 8'h55);
        rd(STAT_OFS, ACT);
        wr(CMD_OFS, CMD_DISABLE);
        rd(STAT_OFS, 32'h0);
        wr(MODE_OFS, 8'h80);
        rd(STAT_OFS, ACT);
    endtask : t_disable

    // Clear, halt 1500 cycles, light idle 500, overflow in a bus release
    task automatic t_runaway();
        int t0;
        wr(CMD_OFS, CMD_CLEAR);
        t0 = cyc_n;
        deep_idle <= 1'b1;
        repeat (750) @(posedge clk_i);
        deep_idle <= 1'b0;
        stop <= 1'b1;
        repeat (750) @(posedge clk_i);
        stop <= 1'b0;
        // Light idle keeps counting, so the overflow stays in the window
        light_idle <= 1'b1;
        repeat (500) @(posedge clk_i);
        light_idle <= 1'b0;
        while (cyc_n - t0 < 66800) @(posedge clk_i);
        chk_cnt(nmi_cnt, 8'h00);
        // Release far shorter than the period
        bus_request_n <= 1'b0;
        wait_grant(1'b0);
        rd(STAT_OFS, 32'h0);
        wr(MODE_OFS, 8'h00);
        while (cyc_n - t0 < 67300) @(posedge clk_i);
        chk_cnt(nmi_cnt, 8'h00);
        bus_request_n <= 1'b1;
        wait_grant(1'b1);
        repeat (3) @(posedge clk_i);
        chk_cnt(nmi_cnt, 8'h01);
        chk_cnt(rst_cnt, 8'h00);
        rd(MODE_OFS, 32'h80);
        rd(STAT_OFS, ACT | DET);
        wr(CMD_OFS, CMD_CLEAR);
        rd(STAT_OFS, ACT);
    endtask : t_runaway

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_mode();
        t_disable();
        t_runaway();
        test_done();
    end

    // Watchdog against a hang
    initial begin
        repeat (90000) @(posedge clk_i);
        n_mismatch++;
        test_done();
    end
endmodule : rwd_top_tb_top
`default_nettype wire
